// *** hdl/local_rom_decoder.v ***
// Notes on behaviour
// [RULE1] Two primary straps pick map option 0-3
// [RULE2] Option 0: 16K boot, 48K movable pair
// [RULE3] Option 1: 32K boot, 32K movable pair
// [RULE4] Option 2: 64K boot, 192K movable pair
// [RULE5] Option 3: 128K/64K boot, 128K/192K movable
// [RULE6] Primary 0-2 need equal secondary; 3 takes 3-7
// [RULE7] Three secondary straps pick size option 0-7
// [RULE8] Secondary 4-7: movable at FC0000, small span (real mode places it at 0C0000)
// [RULE9] Secondary 0-3: movable directly below boot pair
// [RULE10] Bits above device size ignored; contents alias
// [RULE11] Boot pair always ends at address top
// [RULE12] Even bytes first socket, odd bytes second
// [RULE13] One to three waits per pair, default one
// [RULE14] Wait strap field gives nine pairings
// [RULE15] 20-bit real, 24-bit protected addressing
// [RULE16] Local boundaries on fixed 16K blocks
// [RULE17] Expansion range forwarded to expansion bus
// [RULE18] Each wait adds one clock before ready
`timescale 1ns/1ps
`include "rom_decode_defs.vh"

module local_rom_decoder (
   input wire clk,
   input wire resetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire primaryStrapA,
   input wire primaryStrapB,
   input wire secondaryStrapBit0,
   input wire secondaryStrapBit1,
   input wire secondaryStrapBit2,
   input wire [3:0] waitStrapField,
   input wire protectedVirtualMode,
   input wire cpuStart,
   input wire [23:0] cpuAddr,
   input wire cpuByteHighN,
   output reg cpuReady,
   output reg bootEvenSel,
   output reg bootOddSel,
   output reg movEvenSel,
   output reg movOddSel,
   output reg expansionSel,
   output reg [15:0] romAddr
);

   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_DONE = 2'h2;

   // ------------------------------------------------------------------
   // Strap synchronisers
   // ------------------------------------------------------------------
   reg [8:0] strapMeta_r;
   reg [8:0] strapSync_r;

   always @(posedge clk) begin
      if (!resetn) begin
         strapMeta_r <= 9'h000;
         strapSync_r <= 9'h000;
      end else begin
         strapMeta_r <= {waitStrapField, secondaryStrapBit2, secondaryStrapBit1,
                         secondaryStrapBit0, primaryStrapB, primaryStrapA};
         strapSync_r <= strapMeta_r;
      end
   end

   // ------------------------------------------------------------------
   // APB registers
   // ------------------------------------------------------------------
   reg [9:0] ctrl_r;
   reg [1:0] state_r;
   reg [1:0] waitCnt_r;
   reg [1:0] priEff;
   reg [2:0] secEff;
   reg [2:0] secRaw;
   reg comboError;
   reg [1:0] bootWaitCode;
   reg [1:0] movWaitCode;
   reg [1:0] bootWaits;
   reg [1:0] movWaits;
   wire apbAccess = psel & penable & ~pready;
   wire ctrlHit = (paddr == `REG_CTRL_ADDR);
   wire statusHit = (paddr == `REG_STATUS_ADDR);
   wire [31:0] statusWord = {20'h00000, (state_r != ST_IDLE), protectedVirtualMode,
                             comboError, movWaits, bootWaits, secEff, priEff};

   // Answer on the second access-phase edge so pready comes from a flop
   always @(posedge clk) begin
      if (!resetn) begin
         ctrl_r <= `CTRL_RESET;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= apbAccess;
         pslverr <= apbAccess & ~ctrlHit & ~statusHit;
         prdata <= 32'h00000000;
         if (apbAccess && !pwrite && ctrlHit) begin
            prdata <= {22'h000000, ctrl_r};
         end
         if (apbAccess && !pwrite && statusHit) begin
            prdata <= statusWord;
         end
         // Write lands on the edge where the master sees pready high
         if (psel && penable && pready && pwrite && ctrlHit) begin
            ctrl_r <= pwdata[9:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // Option selection
   // ------------------------------------------------------------------
   always @* begin
      if (ctrl_r[`CTRL_OVR_BIT]) begin
         priEff = ctrl_r[`CTRL_PRI_LSB +: 2];
         secRaw = ctrl_r[`CTRL_SEC_LSB +: 3];
         bootWaitCode = ctrl_r[`CTRL_BWAIT_LSB +: 2];
         movWaitCode = ctrl_r[`CTRL_MWAIT_LSB +: 2];
      end else begin
         priEff = {strapSync_r[1], strapSync_r[0]}; // RULE1
         secRaw = strapSync_r[4:2]; // RULE7
         bootWaitCode = strapSync_r[6:5]; // RULE14
         movWaitCode = strapSync_r[8:7]; // RULE14
      end
      // Illegal pairings fall back to the nearest legal secondary
      if (priEff != 2'h3) begin
         secEff = {1'b0, priEff}; // RULE6
         comboError = (secRaw != {1'b0, priEff}); // RULE6
      end else begin
         secEff = (secRaw < 3'h3) ? 3'h3 : secRaw; // RULE6
         comboError = (secRaw < 3'h3); // RULE6
      end
      bootWaits = (bootWaitCode == 2'h0) ? `WAIT_MIN :
                  ((bootWaitCode == 2'h1) ? 2'h2 : 2'h3); // RULE13
      movWaits = (movWaitCode == 2'h0) ? `WAIT_MIN :
                 ((movWaitCode == 2'h1) ? 2'h2 : 2'h3); // RULE13
   end

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------
   reg [23:0] effAddr;
   reg [9:0] blk;
   reg [9:0] topBlk;
   reg [9:0] bootBlks;
   reg [9:0] movBlks;
   reg [9:0] expEnd;
   reg [23:0] movBase;
   reg [23:0] movOfs;
   reg [15:0] bootMask;
   reg [15:0] movMask;
   reg bootHit;
   reg movHit;
   reg expHit;

   always @*begin
      // Real mode sees only 20 address bits
      effAddr = protectedVirtualMode ? cpuAddr : {4'h0, cpuAddr[19:0]}; // RULE15
      blk = effAddr[23:14]; // RULE16
      topBlk = protectedVirtualMode ? `TOP_BLK_PROT : `TOP_BLK_REAL; // RULE15
      case (priEff)
         2'h0: begin
            bootBlks = `BOOT_BLK_OPT0; // RULE2
            movBlks = `MOV_BLK_OPT0; // RULE2
         end
         2'h1: begin
            bootBlks = `BOOT_BLK_OPT1; // RULE3
            movBlks = `MOV_BLK_OPT1; // RULE3
         end
         2'h2: begin
            bootBlks = `BOOT_BLK_OPT2; // RULE4
            movBlks = `MOV_BLK_OPT2; // RULE4
         end
         default: begin
            bootBlks = protectedVirtualMode ? `BOOT_BLK_OPT3P : `BOOT_BLK_OPT3R; // RULE5
            movBlks = protectedVirtualMode ? `MOV_BLK_OPT3P : `MOV_BLK_OPT3R; // RULE5
         end
      endcase
      if (protectedVirtualMode) begin
         expEnd = `EXP_END_PROT;
      end else begin
         expEnd = (priEff[1]) ? `EXP_END_REAL_HIGH : `EXP_END_REAL_LOW; // RULE4
      end
      case (secEff)
         3'h0: movMask = `MASK_8K;
         3'h1: movMask = `MASK_16K;
         3'h2: movMask = `MASK_32K;
         3'h3: movMask = `MASK_64K;
         3'h4: movMask = `MASK_2K; // RULE8
         3'h5: movMask = `MASK_8K; // RULE8
         3'h6: movMask = `MASK_16K; // RULE8
         default: movMask = `MASK_32K; // RULE8
      endcase
      bootMask = secEff[2] ? `MASK_64K : movMask; // RULE9
      // Boot pair hangs off the top of the space
      bootHit = (blk > topBlk - bootBlks); // RULE11
      movBase = {topBlk - `MOV_SPLIT_OFS, 14'h0000};
      movOfs = effAddr - movBase;
      if (secEff[2]) begin
         // Pair span is two devices of the selected size
         movHit = (blk >= topBlk - `MOV_SPLIT_OFS) &&
                  (movOfs[23:1] <= {7'h00, movMask}); // RULE8
      end else begin
         movHit = (blk <= topBlk - bootBlks) &&
                  (blk > topBlk - bootBlks - movBlks); // RULE9
      end
      expHit = ~bootHit & ~movHit & (blk <= expEnd); // RULE17
   end

   // ------------------------------------------------------------------
   // Access sequencer
   // ------------------------------------------------------------------
   always @(posedge clk) begin
      if (!resetn) begin
         state_r <= ST_IDLE;
         waitCnt_r <= 2'h0;
         cpuReady <= 1'b0;
         bootEvenSel <= 1'b0;
         bootOddSel <= 1'b0;
         movEvenSel <= 1'b0;
         movOddSel <= 1'b0;
         expansionSel <= 1'b0;
         romAddr <= 16'h0000;
      end else begin
         case (state_r)
            ST_IDLE: begin
               cpuReady <= 1'b0;
               expansionSel <= 1'b0;
               if (cpuStart) begin
                  // Upper bits dropped so small devices alias
                  romAddr <= effAddr[16:1] & (bootHit ? bootMask : movMask); // RULE10
                  bootEvenSel <= bootHit & ~effAddr[0]; // RULE12
                  bootOddSel <= bootHit & (effAddr[0] | ~cpuByteHighN); // RULE12
                  movEvenSel <= movHit & ~effAddr[0]; // RULE12
                  movOddSel <= movHit & (effAddr[0] | ~cpuByteHighN); // RULE12
                  expansionSel <= expHit; // RULE17
                  // Expansion cycles get their ready from the expansion bus
                  if (!expHit) begin
                     waitCnt_r <= bootHit ? bootWaits : (movHit ? movWaits : `WAIT_MIN);
                     state_r <= ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               if (waitCnt_r == 2'h1) begin
                  cpuReady <= 1'b1; // RULE18
                  state_r <= ST_DONE;
               end else begin
                  waitCnt_r <= waitCnt_r - 2'h1; // RULE18
               end
            end
            ST_DONE: begin
               cpuReady <= 1'b0;
               bootEvenSel <= 1'b0;
               bootOddSel <= 1'b0;
               movEvenSel <= 1'b0;
               movOddSel <= 1'b0;
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // local_rom_decoder

// *** hdl/rom_decode_defs.vh ***
`ifndef ROM_DECODE_DEFS_VH
`define ROM_DECODE_DEFS_VH

// ---------------------------------------------------------------------
// Register map (APB byte addresses)
// ---------------------------------------------------------------------
`define REG_CTRL_ADDR 12'h000
`define REG_STATUS_ADDR 12'h004
`define CTRL_RESET 10'h000
`define CTRL_OVR_BIT 0
`define CTRL_PRI_LSB 1
`define CTRL_SEC_LSB 3
`define CTRL_BWAIT_LSB 6
`define CTRL_MWAIT_LSB 8

// ---------------------------------------------------------------------
// 16K block indices (address bits 23:14)
// ---------------------------------------------------------------------
`define TOP_BLK_PROT 10'h3FF
`define TOP_BLK_REAL 10'h03F
`define EXP_END_PROT 10'h37F
`define EXP_END_REAL_LOW 10'h037
`define EXP_END_REAL_HIGH 10'h027
`define MOV_SPLIT_OFS 10'h00F

// Boot / movable pair sizes in 16K blocks per primary option
`define BOOT_BLK_OPT0 10'h001
`define MOV_BLK_OPT0 10'h003
`define BOOT_BLK_OPT1 10'h002
`define MOV_BLK_OPT1 10'h002
`define BOOT_BLK_OPT2 10'h004
`define MOV_BLK_OPT2 10'h00C
`define BOOT_BLK_OPT3P 10'h008
`define MOV_BLK_OPT3P 10'h008
`define BOOT_BLK_OPT3R 10'h004
`define MOV_BLK_OPT3R 10'h00C

// ---------------------------------------------------------------------
// Device word masks (device size minus one)
// ---------------------------------------------------------------------
`define MASK_2K 16'h07FF
`define MASK_8K 16'h1FFF
`define MASK_16K 16'h3FFF
`define MASK_32K 16'h7FFF
`define MASK_64K 16'hFFFF

// Wait-state code per pair: 0 -> 1, 1 -> 2, 2 or 3 -> 3
`define WAIT_MIN 2'h1

`endif

// *** verif/local_rom_decoder_checker.sv ***
`timescale 1ns/1ps
module local_rom_decoder_checker (
   input wire clk,
   input wire resetn,
   input wire cpuStart,
   input wire [23:0] cpuAddr,
   input wire cpuByteHighN,
   input wire protectedVirtualMode,
   input wire [3:0] waitStrapField,
   input wire cpuReady,
   input wire bootEvenSel,
   input wire bootOddSel,
   input wire movEvenSel,
   input wire movOddSel,
   input wire expansionSel
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   wire bootSel = bootEvenSel | bootOddSel;
   wire movSel = movEvenSel | movOddSel;
   wire addr0 = cpuAddr[0];
   chk_ready_ends: assert property (cpuReady |=> !cpuReady && !bootSel && !movSel)
      else $error("ready or select stayed up");
   chk_boot_one: assert property ($rose(bootSel) && waitStrapField[1:0] == 2'h0 |=> cpuReady)
      else $error("boot single wait wrong");
   chk_mov_two: assert property ($rose(movSel) && waitStrapField[3:2] == 2'h1
      |=> !cpuReady ##1 cpuReady)
      else $error("movable double wait wrong");
   chk_mov_three: assert property ($rose(movSel) && waitStrapField[3] |=> !cpuReady [*2] ##1 cpuReady)
      else $error("movable triple wait wrong");
   chk_sel_excl: assert property ($onehot0({bootSel, movSel, expansionSel}))
      else $error("two targets at once");
   chk_even_route: assert property ($rose(bootEvenSel) || $rose(movEvenSel) |-> !$past(addr0))
      else $error("even socket on odd byte");
   chk_odd_route: assert property ($rose(bootOddSel) || $rose(movOddSel)
      |-> $past(addr0) || !$past(cpuByteHighN))
      else $error("odd socket without cause");
   chk_boot_top: assert property (cpuStart
      && cpuAddr[23:14] == (protectedVirtualMode ? 10'h3FF : 10'h03F) |=> bootSel)
      else $error("top block not boot pair");
   chk_low_exp: assert property (cpuStart && protectedVirtualMode && cpuAddr[23:22] == 2'h0
      |-> ##[1:2] expansionSel)
      else $error("low address not forwarded");
   chk_exp_pulse: assert property (expansionSel |-> !cpuReady ##1 !expansionSel)
      else $error("forward pulse wrong");
endmodule // local_rom_decoder_checker

bind local_rom_decoder local_rom_decoder_checker chk_u (
   .clk(clk), .resetn(resetn), .cpuStart(cpuStart), .cpuAddr(cpuAddr),
   .cpuByteHighN(cpuByteHighN), .protectedVirtualMode(protectedVirtualMode),
   .waitStrapField(waitStrapField), .cpuReady(cpuReady), .bootEvenSel(bootEvenSel),
   .bootOddSel(bootOddSel), .movEvenSel(movEvenSel), .movOddSel(movOddSel),
   .expansionSel(expansionSel)
);

// *** verif/cpu_bus_model.sv ***
`timescale 1ns/1ps
module cpu_bus_model (
   input wire clk,
   input wire cpuReady,
   input wire expansionSel,
   output logic cpuStart = 1'b0,
   output logic [23:0] cpuAddr = 24'h000000,
   output logic cpuByteHighN = 1'b1
);
   task access(input logic [23:0] a, input logic b, output int n, output logic ex);
      {cpuStart, cpuAddr, cpuByteHighN} <= {1'b1, a, b};
      @(posedge clk);
      cpuStart <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         ex = expansionSel;
      end while (cpuReady !== 1'b1 && ex !== 1'b1 && n < 12);
      // Flip released lines so a stale address never looks valid
      {cpuAddr, cpuByteHighN} <= {~a, ~b};
   endtask
endmodule // cpu_bus_model

// *** verif/local_rom_decoder_tb_top.sv ***
`timescale 1ns/1ps
module local_rom_decoder_tb_top;
   typedef struct {
      logic [1:0] p;
      logic [2:0] s;
      logic v;
      logic [23:0] a;
      logic b;
      logic [3:0] w;
      logic [4:0] e;
      logic [15:0] m;
   } row_t;
   logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic priA = 1'b1, priB = 1'b0, sec0 = 1'b1, sec1 = 1'b0, sec2 = 1'b0, pvm = 1'b1;
   logic [3:0] waitCode = 4'h0;
   wire [31:0] prdata;
   wire pready, pslverr, cpuStart, cpuByteHighN, cpuReady, bootE, bootO, movE, movO, expSel;
   wire [23:0] cpuAddr;
   wire [15:0] romAddr;
   logic [32:0] rsp;
   logic [1:0] code;
   logic ex;
   int miscompares = 0, num_checks = 0, n;
   row_t rows [13] = '{
      '{2'h0, 3'h0, 1'h1, 24'hFFC000, 1'h1, 4'h0, 5'h10, 16'h1FFF},
      '{2'h0, 3'h0, 1'h0, 24'h0FBFFF, 1'h1, 4'h4, 5'h02, 16'h1FFF},
      '{2'h1, 3'h1, 1'h1, 24'hFF8001, 1'h1, 4'h2, 5'h08, 16'h3FFF},
      '{2'h2, 3'h2, 1'h1, 24'hFC0002, 1'h1, 4'hC, 5'h04, 16'h7FFF},
      '{2'h2, 3'h2, 1'h0, 24'h0A0000, 1'h1, 4'h0, 5'h00, 16'h0000},
      '{2'h3, 3'h3, 1'h1, 24'hFE0000, 1'h0, 4'h1, 5'h18, 16'hFFFF},
      '{2'h3, 3'h4, 1'h1, 24'hFC0800, 1'h1, 4'h5, 5'h04, 16'h07FF},
      '{2'h3, 3'h5, 1'h1, 24'hFC4000, 1'h1, 4'h0, 5'h00, 16'h0000},
      '{2'h3, 3'h6, 1'h0, 24'h0C7FFF, 1'h1, 4'h9, 5'h02, 16'h3FFF},
      '{2'h3, 3'h7, 1'h1, 24'hFCFFFE, 1'h1, 4'h8, 5'h04, 16'h7FFF},
      '{2'h1, 3'h1, 1'h1, 24'h123456, 1'h1, 4'h0, 5'h01, 16'h0000},
      '{2'h0, 3'h0, 1'h0, 24'h0DFFFF, 1'h1, 4'h0, 5'h01, 16'h0000},
      '{2'h0, 3'h5, 1'h1, 24'hFF8000, 1'h1, 4'h6, 5'h04, 16'h1FFF}
   };

   local_rom_decoder dut_u (
      .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .primaryStrapA(priA), .primaryStrapB(priB), .secondaryStrapBit0(sec0),
      .secondaryStrapBit1(sec1), .secondaryStrapBit2(sec2), .waitStrapField(waitCode),
      .protectedVirtualMode(pvm), .cpuStart(cpuStart), .cpuAddr(cpuAddr),
      .cpuByteHighN(cpuByteHighN), .cpuReady(cpuReady), .bootEvenSel(bootE),
      .bootOddSel(bootO), .movEvenSel(movE), .movOddSel(movO), .expansionSel(expSel),
      .romAddr(romAddr)
   );
   cpu_bus_model cpu_u (.clk(clk), .cpuReady(cpuReady), .expansionSel(expSel),
      .cpuStart(cpuStart), .cpuAddr(cpuAddr), .cpuByteHighN(cpuByteHighN));

   initial begin
      forever #10 clk = ~clk;
   end

   task check(input logic [32:0] got, input logic [32:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task final_report;
      if (miscompares == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
      int k;
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         miscompares++;
      end
      r = {pslverr, prdata};
      {psel, penable} <= 2'h0;
      @(posedge clk);
   endtask

   // ---------------------------------------------
   // Map table, then reset and register access
   // ---------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      foreach (rows[i]) begin
         {priB, priA, sec2, sec1, sec0} <= {rows[i].p, rows[i].s};
         {pvm, waitCode} <= {rows[i].v, rows[i].w};
         // Straps pass a two-stage synchroniser
         repeat (4) @(posedge clk);
         cpu_u.access(rows[i].a, rows[i].b, n, ex);
         if (n >= 12) miscompares++;
         check({28'h0, bootE, bootO, movE, movO, ex}, {28'h0, rows[i].e});
         if (rows[i].m != 16'h0000) check({17'h0, romAddr}, {17'h0, rows[i].a[16:1] & rows[i].m});
         code = (rows[i].e[4:3] != 2'h0) ? rows[i].w[1:0] : rows[i].w[3:2];
         if (!rows[i].e[0]) check(33'(n), (rows[i].e[4:1] == 4'h0 || code == 2'h0) ? 33'h2 : (code == 2'h1 ? 33'h3 : 33'h4));
      end
      resetn <= 1'b0;
      {priB, priA, sec2, sec1, sec0, pvm, waitCode} <= {5'h09, 1'b1, 4'h0};
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, 12'h004, 32'h00000000, rsp);
      check(rsp, 33'h0000004A5);
      apb(1'b0, 12'h000, 32'h00000000, rsp);
      check(rsp, 33'h000000000);
      apb(1'b1, 12'h000, 32'hFFFFFFFE, rsp);
      apb(1'b0, 12'h000, 32'h00000000, rsp);
      check(rsp, 33'h0000003FE);
      apb(1'b0, 12'h008, 32'h00000000, rsp);
      check(rsp, 33'h100000000);
      // Override: primary 3, secondary 4, both wait codes set to 0 in the control register
      apb(1'b1, 12'h000, 32'h00000027, rsp);
      apb(1'b0, 12'h004, 32'h00000000, rsp);
      check(rsp, 33'h0000004B3);
      cpu_u.access(24'hFE0000, 1'b1, n, ex);
      if (n >= 12) miscompares++;
      check({28'h0, bootE, bootO, movE, movO, ex}, 33'h000000010);
      check(33'(n), 33'h000000002);
      final_report;
   end
endmodule // local_rom_decoder_tb_top
